// *** shared/mlsd_defs.svh ***
// Constants of the multiply-and-load / multiply-and-subtract datapath.
`ifndef MLSD_DEFS_SVH
`define MLSD_DEFS_SVH
`define MLSD_OP_W        24
`define MLSD_P_W         48
`define MLSD_MA_W        52
`define MLSD_ST_W        3
`define MLSD_OFF_CTRL    8'h00
`define MLSD_OFF_STAT    8'h04
`define MLSD_OFF_MASK    8'h08
`define MLSD_OFF_FLAG    8'h0c
`define MLSD_OFF_MA0L    8'h10
`define MLSD_OFF_MA0H    8'h14
`define MLSD_OFF_MA1L    8'h18
`define MLSD_OFF_MA1H    8'h1c
`define MLSD_OFF_PL      8'h20
`define MLSD_OFF_PH      8'h24
`define MLSD_OFF_X0      8'h28
`define MLSD_OFF_X1      8'h2c
`define MLSD_OFF_Y0      8'h30
`define MLSD_OFF_Y1      8'h34
`define MLSD_OFF_A0      8'h38
`define MLSD_OFF_A1      8'h3c
`define MLSD_OFF_A2      8'h40
`define MLSD_OFF_A3      8'h44
`define MLSD_CTRL_EN     0
`define MLSD_CTRL_MVCLR  1
`define MLSD_CTRL_RST    1'h1
`define MLSD_MASK_RST    3'h0
`define MLSD_ST_DONE     0
`define MLSD_ST_MV       1
`define MLSD_ST_LDV      2
`define MLSD_Y_PTR       3'h3
`define MLSD_RESP_OKAY   2'h0
`define MLSD_RESP_DECERR 2'h3
`endif

// *** shared/mlsd_pkg.sv ***
// Types and shared helpers of the multiply-and-load / multiply-and-subtract datapath.
package mlsd_pkg;
  typedef enum logic {
    OP_LOAD = 1'b0,
    OP_SUB  = 1'b1
  } mlsd_op_t;
  typedef enum logic [1:0] {
    MOVE_NONE = 2'b00,
    MOVE_TWO  = 2'b01,
    MOVE_ACC  = 2'b10,
    MOVE_MEM  = 2'b11
  } mlsd_move_t;
  typedef enum logic [1:0] {
    SH_PLAIN = 2'b00,
    SH_RIGHT = 2'b01,
    SH_LEFT  = 2'b10
  } mlsd_shift_t;
  typedef struct packed {
    logic        valid;
    mlsd_op_t    op;
    logic        acc_sel;
    logic        x_sel;
    logic        y_sel;
    mlsd_move_t  move;
    logic        x_dst;
    logic        y_dst;
    logic        x_ptr;
    logic [1:0]  ga_dst;
    logic        src_acc;
    mlsd_shift_t shift;
    logic [2:0]  mem_dst;
    logic [2:0]  mem_ptr;
  } mlsd_instr_t;
  typedef struct packed {
    logic [1:0] guard_overflow_flag;
    logic       guard_overflow_sticky;
    logic       zero;
    logic       overflow;
    logic       negative;
  } mlsd_flags_t;
  // High when the top bits of v are not a plain sign extension.
  function automatic logic mlsd_top_ovf(input logic [51:0] v, input logic left);
    logic [5:0] t;
    t = v[51:46];
    if (left) return !((&t) || !(|t));
    return !((&t[5:1]) || !(|t[5:1]));
  endfunction
endpackage

// *** rtl/mlsd_mult.sv ***
// Signed operand multiplier feeding the product register.
`timescale 1ns/10ps
module mlsd_mult #(
  parameter int W = 24
) (
  // Operands
  input  logic [W-1:0]   a_i,
  input  logic [W-1:0]   b_i,
  // Product
  output logic [2*W-1:0] prod_o
);
  assign prod_o = $signed(a_i) * $signed(b_i);
endmodule

// *** rtl/mlsd_acc_unit.sv ***
// Multiplier accumulator update: load or subtract, with guard overflow detection.
`timescale 1ns/10ps
`include "mlsd_defs.svh"
module mlsd_acc_unit
  import mlsd_pkg::*;
(
  // Operands
  input  logic [`MLSD_MA_W-1:0] acc_i,
  input  logic [`MLSD_P_W-1:0]  prod_i,
  input  logic                  sub_i,
  // Result and overflow indications
  output logic [`MLSD_MA_W-1:0] result_o,
  output logic                  guard_o,
  output logic                  wrap_o
);
  logic [`MLSD_MA_W:0] diff;
  logic [`MLSD_MA_W:0] pext;

  assign pext = {{(`MLSD_MA_W-`MLSD_P_W+1){prod_i[`MLSD_P_W-1]}}, prod_i};
  assign diff = {acc_i[`MLSD_MA_W-1], acc_i} - pext;
  // A load of a sign-extended product can never wrap the guard bits.
  assign result_o = sub_i ? diff[`MLSD_MA_W-1:0] : pext[`MLSD_MA_W-1:0];
  assign guard_o  = mlsd_top_ovf(result_o, 1'b0);
  assign wrap_o   = sub_i & (diff[`MLSD_MA_W] ^ diff[`MLSD_MA_W-1]);
endmodule

// *** rtl/mlsd_datapath.sv ***
// Multiply-and-load / multiply-and-subtract datapath with AXI4-Lite register access.
`timescale 1ns/10ps
`include "mlsd_defs.svh"
// Overview of operation
// RULE1 - Load copies the product register into the chosen 52-bit accumulator.
// RULE2 - Subtract writes accumulator minus product back into the same accumulator.
// RULE3 - Each operation also stores the selected X times Y into the product.
// RULE4 - Two-move form loads one X register and one Y register from memory.
// RULE5 - Two-move form addresses X via pointer 0 or 1, Y via pointer 3.
// RULE6 - Accumulator guard flag is set on overflow into guard bits, else cleared.
// RULE7 - Sticky flag sets when guard bits wrap, otherwise keeps its value.
// RULE8 - Each accumulator has its own guard flag, updated only for it.
// RULE9 - One-move form: general accumulator from accumulator, or register from memory.
// RULE10 - One-move source is memory or the upper 24 bits of an accumulator.
// RULE11 - Right-shift source gives bits 47 to 24 shifted right by one.
// RULE12 - Left-shift source gives bits 47 to 24 shifted left by one.
// RULE13 - General accumulator load sets zero flag exactly when value is zero.
// RULE14 - General accumulator load sets overflow flag when the load overflows.
// RULE15 - General accumulator load sets negative flag when value is negative.
// RULE16 - All updates commit together from the values held before the operation.
module mlsd_datapath
  import mlsd_pkg::*;
(
  // Clock and reset
  input  logic                     clock_i,
  input  logic                     resetn_i,
  // Instruction issue from the host core
  input  mlsd_instr_t              instr_i,
  output logic                     instr_ready_o,
  // Data memory pointers and read data
  output logic [2:0]               x_ptr_sel_o,
  output logic [2:0]               y_ptr_sel_o,
  output logic [2:0]               mem_ptr_sel_o,
  input  logic [`MLSD_OP_W-1:0]    x_mem_data_i,
  input  logic [`MLSD_OP_W-1:0]    y_mem_data_i,
  // Flags and interrupt
  output mlsd_flags_t              flags_o,
  output logic                     irq_o,
  // AXI4-Lite write channels
  input  logic [7:0]               axi_awaddr_i,
  input  logic                     axi_awvalid_i,
  output logic                     axi_awready_o,
  input  logic [31:0]              axi_wdata_i,
  input  logic [3:0]               axi_wstrb_i,
  input  logic                     axi_wvalid_i,
  output logic                     axi_wready_o,
  output logic [1:0]               axi_bresp_o,
  output logic                     axi_bvalid_o,
  input  logic                     axi_bready_i,
  // AXI4-Lite read channels
  input  logic [7:0]               axi_araddr_i,
  input  logic                     axi_arvalid_i,
  output logic                     axi_arready_o,
  output logic [31:0]              axi_rdata_o,
  output logic [1:0]               axi_rresp_o,
  output logic                     axi_rvalid_o,
  input  logic                     axi_rready_i
);
  logic [1:0][`MLSD_MA_W-1:0] ma_q;
  logic [`MLSD_P_W-1:0]       p_q;
  logic [1:0][`MLSD_OP_W-1:0] x_q;
  logic [1:0][`MLSD_OP_W-1:0] y_q;
  logic [3:0][`MLSD_OP_W-1:0] a_q;
  logic [1:0]                 vm_q;
  logic                       mv_q;
  logic                       z_q;
  logic                       v_q;
  logic                       n_q;
  logic                       ctrl_en_q;
  logic [`MLSD_ST_W-1:0]      mask_q;
  logic [`MLSD_ST_W-1:0]      stat_q;
  logic [`MLSD_ST_W-1:0]      stat_set;
  logic [`MLSD_ST_W-1:0]      stat_clr;
  logic                       fire;
  logic [`MLSD_MA_W-1:0]      ma_sel_w;
  logic [`MLSD_MA_W-1:0]      ma_res_w;
  logic [`MLSD_MA_W-1:0]      p_ext;
  logic [`MLSD_MA_W-1:0]      src_w;
  logic [`MLSD_OP_W-1:0]      x_sel_w;
  logic [`MLSD_OP_W-1:0]      y_sel_w;
  logic [`MLSD_OP_W-1:0]      mem_w;
  logic [`MLSD_OP_W-1:0]      ga_val_w;
  logic [`MLSD_P_W-1:0]       prod_w;
  logic [1:0]                 ga_idx_w;
  logic                       ga_we_w;
  logic                       ga_v_w;
  logic                       vm_w;
  logic                       wrap_w;
  logic                       mv_evt_w;
  logic                       mv_clr_w;
  logic                       aw_hold_q;
  logic                       w_hold_q;
  logic [7:0]                 awaddr_q;
  logic [31:0]                wdata_q;
  logic [3:0]                 wstrb_q;
  logic                       bvalid_q;
  logic [1:0]                 bresp_q;
  logic                       rvalid_q;
  logic [1:0]                 rresp_q;
  logic [31:0]                rdata_q;
  logic                       wr_fire;
  logic                       wr_ok;
  logic                       rd_fire;
  logic                       rd_hit;
  logic [31:0]                rd_mux;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  // Instructions are taken in the cycle they are offered; disabling stalls the core.
  assign instr_ready_o = ctrl_en_q;
  assign fire          = instr_i.valid & ctrl_en_q;
  assign ma_sel_w      = ma_q[instr_i.acc_sel];
  assign x_sel_w       = x_q[instr_i.x_sel];
  assign y_sel_w       = y_q[instr_i.y_sel];
  assign p_ext         = {{(`MLSD_MA_W-`MLSD_P_W){p_q[`MLSD_P_W-1]}}, p_q};
  assign x_ptr_sel_o   = {2'h0, instr_i.x_ptr}; // [RULE5]
  assign y_ptr_sel_o   = `MLSD_Y_PTR; // [RULE5]
  assign mem_ptr_sel_o = instr_i.mem_ptr;

  mlsd_mult #(
    .W (`MLSD_OP_W)
  ) u_mult (
    .a_i    (x_sel_w),
    .b_i    (y_sel_w),
    .prod_o (prod_w)
  );

  mlsd_acc_unit u_acc (
    .acc_i    (ma_sel_w),
    .prod_i   (p_q),
    .sub_i    (instr_i.op == OP_SUB),
    .result_o (ma_res_w),
    .guard_o  (vm_w),
    .wrap_o   (wrap_w)
  );

  assign mv_evt_w = fire & wrap_w;

  // One-move source selection and general accumulator load value.
  always_comb begin
    src_w    = ma_q[instr_i.src_acc];
    mem_w    = instr_i.mem_ptr[2] ? y_mem_data_i : x_mem_data_i; // [RULE10]
    ga_we_w  = 1'b0;
    ga_idx_w = instr_i.ga_dst;
    ga_val_w = mem_w;
    ga_v_w   = 1'b0;
    if (instr_i.move == MOVE_ACC) begin // [RULE9]
      ga_we_w = fire;
      case (instr_i.shift)
        SH_RIGHT: begin
          ga_val_w = {src_w[47], src_w[47:25]}; // [RULE11]
          ga_v_w   = mlsd_top_ovf(src_w, 1'b0);
        end
        SH_LEFT: begin
          ga_val_w = {src_w[46:24], 1'b0}; // [RULE12]
          ga_v_w   = mlsd_top_ovf(src_w, 1'b1);
        end
        default: begin
          ga_val_w = src_w[47:24]; // [RULE10]
          ga_v_w   = mlsd_top_ovf(src_w, 1'b0);
        end
      endcase
    end else if (instr_i.move == MOVE_MEM && !instr_i.mem_dst[2]) begin // [RULE9]
      ga_we_w  = fire;
      ga_idx_w = instr_i.mem_dst[1:0];
    end
  end

  // Accumulator and product commit at one edge, both computed from the old state.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ma_q <= '0;
      p_q  <= '0;
    end else if (fire) begin
      ma_q[instr_i.acc_sel] <= ma_res_w; // [RULE1] [RULE2] [RULE16]
      p_q                   <= prod_w; // [RULE3] [RULE16]
    end
  end

  // Operand registers from the parallel moves.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      x_q <= '0;
      y_q <= '0;
    end else if (fire) begin
      if (instr_i.move == MOVE_TWO) begin
        x_q[instr_i.x_dst] <= x_mem_data_i; // [RULE4]
        y_q[instr_i.y_dst] <= y_mem_data_i; // [RULE4]
      end else if (instr_i.move == MOVE_MEM && instr_i.mem_dst[2]) begin
        if (instr_i.mem_dst[1]) begin
          y_q[instr_i.mem_dst[0]] <= mem_w; // [RULE9]
        end else begin
          x_q[instr_i.mem_dst[0]] <= mem_w; // [RULE9]
        end
      end
    end
  end

  // General accumulators and their load flags.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      a_q <= '0;
      z_q <= 1'b0;
      v_q <= 1'b0;
      n_q <= 1'b0;
    end else if (ga_we_w) begin
      a_q[ga_idx_w] <= ga_val_w; // [RULE10]
      z_q           <= (ga_val_w == '0); // [RULE13]
      v_q           <= ga_v_w; // [RULE14]
      n_q           <= ga_val_w[`MLSD_OP_W-1]; // [RULE15]
    end
  end

  // Guard flags; the sticky one is only cleared by software, and a new event wins.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vm_q <= '0;
      mv_q <= 1'b0;
    end else begin
      if (fire) begin
        vm_q[instr_i.acc_sel] <= vm_w; // [RULE6] [RULE8]
      end
      if (mv_evt_w) begin
        mv_q <= 1'b1; // [RULE7]
      end else if (mv_clr_w) begin
        mv_q <= 1'b0;
      end
    end
  end

  assign flags_o = '{guard_overflow_flag: vm_q, guard_overflow_sticky: mv_q,
                     zero: z_q, overflow: v_q, negative: n_q};

  // Interrupt status: set wins over the clear done by reading the register.
  assign stat_set = {fire & ga_we_w & ga_v_w, mv_evt_w, fire};
  assign stat_clr = (rd_fire && axi_araddr_i == `MLSD_OFF_STAT) ? stat_q : '0;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
    end
  end
  assign irq_o = |(stat_q & mask_q);

  // AXI4-Lite write path: address and data are held independently.
  assign axi_awready_o = !aw_hold_q && !bvalid_q;
  assign axi_wready_o  = !w_hold_q && !bvalid_q;
  assign wr_fire       = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_ok         = (awaddr_q[1:0] == 2'h0) && (awaddr_q <= `MLSD_OFF_A3);
  assign mv_clr_w      = wr_fire && awaddr_q == `MLSD_OFF_CTRL && wstrb_q[0] &&
                         wdata_q[`MLSD_CTRL_MVCLR];
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `MLSD_RESP_OKAY;
    end else begin
      if (axi_awvalid_i && axi_awready_o) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= axi_awaddr_i;
      end
      if (axi_wvalid_i && axi_wready_o) begin
        w_hold_q <= 1'b1;
        wdata_q  <= axi_wdata_i;
        wstrb_q  <= axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? `MLSD_RESP_OKAY : `MLSD_RESP_DECERR;
      end else if (bvalid_q && axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign axi_bvalid_o = bvalid_q;
  assign axi_bresp_o  = bresp_q;

  // Control and mask; writes to read-only words are accepted and dropped.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_en_q <= `MLSD_CTRL_RST;
      mask_q    <= `MLSD_MASK_RST;
    end else if (wr_fire && wstrb_q[0]) begin
      if (awaddr_q == `MLSD_OFF_CTRL) begin
        ctrl_en_q <= wdata_q[`MLSD_CTRL_EN];
      end
      if (awaddr_q == `MLSD_OFF_MASK) begin
        mask_q <= wdata_q[`MLSD_ST_W-1:0];
      end
    end
  end

  // AXI4-Lite read path.
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = '0;
    case (axi_araddr_i)
      `MLSD_OFF_CTRL: rd_mux = {31'h0, ctrl_en_q};
      `MLSD_OFF_STAT: rd_mux = {29'h0, stat_q};
      `MLSD_OFF_MASK: rd_mux = {29'h0, mask_q};
      `MLSD_OFF_FLAG: rd_mux = {26'h0, flags_o};
      `MLSD_OFF_MA0L: rd_mux = ma_q[0][31:0];
      `MLSD_OFF_MA0H: rd_mux = {12'h0, ma_q[0][51:32]};
      `MLSD_OFF_MA1L: rd_mux = ma_q[1][31:0];
      `MLSD_OFF_MA1H: rd_mux = {12'h0, ma_q[1][51:32]};
      `MLSD_OFF_PL:   rd_mux = p_q[31:0];
      `MLSD_OFF_PH:   rd_mux = {16'h0, p_q[47:32]};
      `MLSD_OFF_X0:   rd_mux = {8'h0, x_q[0]};
      `MLSD_OFF_X1:   rd_mux = {8'h0, x_q[1]};
      `MLSD_OFF_Y0:   rd_mux = {8'h0, y_q[0]};
      `MLSD_OFF_Y1:   rd_mux = {8'h0, y_q[1]};
      `MLSD_OFF_A0:   rd_mux = {8'h0, a_q[0]};
      `MLSD_OFF_A1:   rd_mux = {8'h0, a_q[1]};
      `MLSD_OFF_A2:   rd_mux = {8'h0, a_q[2]};
      `MLSD_OFF_A3:   rd_mux = {8'h0, a_q[3]};
      default:        rd_hit = 1'b0;
    endcase
  end

  assign axi_arready_o = !rvalid_q;
  assign rd_fire       = axi_arvalid_i && !rvalid_q;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `MLSD_RESP_OKAY;
      rdata_q  <= '0;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_hit ? `MLSD_RESP_OKAY : `MLSD_RESP_DECERR;
      rdata_q  <= rd_mux;
    end else if (axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end
  assign axi_rvalid_o = rvalid_q;
  assign axi_rresp_o  = rresp_q;
  assign axi_rdata_o  = rdata_q;

  sequence s_load;
    fire && instr_i.op == OP_LOAD;
  endsequence
  sequence s_sub;
    fire && instr_i.op == OP_SUB;
  endsequence
  sequence s_two;
    fire && instr_i.move == MOVE_TWO;
  endsequence

  chk_load_copy: assert property ( // [RULE1]
    s_load |=> ma_q[$past(instr_i.acc_sel)] == $past(p_ext))
    else $error("load did not copy the product");
  chk_sub_diff: assert property ( // [RULE2]
    s_sub |=> ma_q[$past(instr_i.acc_sel)] == $past(ma_sel_w) - $past(p_ext))
    else $error("subtract result wrong");
  chk_new_product: assert property ( // [RULE3]
    fire |=> p_q == $past({{24{x_sel_w[23]}}, x_sel_w}) * $past({{24{y_sel_w[23]}}, y_sel_w}))
    else $error("product not formed from old operands");
  chk_two_moves: assert property ( // [RULE4]
    s_two |=> x_q[$past(instr_i.x_dst)] == $past(x_mem_data_i)
           && y_q[$past(instr_i.y_dst)] == $past(y_mem_data_i))
    else $error("two-move load wrong");
  chk_ptr_select: assert property ( // [RULE5]
    s_two |-> x_ptr_sel_o[2:1] == 2'h0 && y_ptr_sel_o == 3'h3)
    else $error("pointer selection wrong");
  chk_guard_flag: assert property ( // [RULE6]
    fire |=> vm_q[$past(instr_i.acc_sel)] == mlsd_top_ovf(ma_q[$past(instr_i.acc_sel)], 1'b0))
    else $error("guard flag does not match accumulator");
  chk_sticky_hold: assert property ( // [RULE7]
    !mv_evt_w && !mv_clr_w |=> mv_q == $past(mv_q))
    else $error("sticky flag changed without cause");
  chk_sticky_set: assert property ( // [RULE7]
    mv_evt_w |=> mv_q ##1 mv_q || $past(mv_clr_w))
    else $error("sticky flag not set");
  chk_flag_split: assert property ( // [RULE8]
    fire |=> vm_q[!$past(instr_i.acc_sel)] == $past(vm_q[!instr_i.acc_sel]))
    else $error("other accumulator guard flag changed");
  chk_move_target: assert property ( // [RULE9]
    fire && instr_i.move == MOVE_ACC |=> a_q[$past(instr_i.ga_dst)] == $past(ga_val_w))
    else $error("accumulator move lost");
  chk_high_part: assert property ( // [RULE10]
    instr_i.move == MOVE_ACC && instr_i.shift == SH_PLAIN |-> ga_val_w == src_w[47:24])
    else $error("upper portion wrong");
  chk_shift_right: assert property ( // [RULE11]
    instr_i.move == MOVE_ACC && instr_i.shift == SH_RIGHT
      |-> $signed(ga_val_w) == ($signed(src_w[47:24]) >>> 1))
    else $error("right shift wrong");
  chk_shift_left: assert property ( // [RULE12]
    instr_i.move == MOVE_ACC && instr_i.shift == SH_LEFT |-> ga_val_w == (src_w[47:24] << 1))
    else $error("left shift wrong");
  chk_zero_flag: assert property ( // [RULE13]
    ga_we_w |=> z_q == (a_q[$past(ga_idx_w)] == '0))
    else $error("zero flag wrong");
  chk_ovf_flag: assert property ( // [RULE14]
    ga_we_w && instr_i.move == MOVE_MEM |=> !v_q)
    else $error("overflow flag set by memory load");
  chk_neg_flag: assert property ( // [RULE15]
    ga_we_w |=> n_q == a_q[$past(ga_idx_w)][23])
    else $error("negative flag wrong");
  chk_idle_hold: assert property ( // [RULE16]
    !fire |=> $stable(ma_q) && $stable(p_q) && $stable(a_q))
    else $error("state changed without an instruction");
endmodule

// *** verification/mlsd_mem_model.sv ***
// Data memory model answering the datapath pointer selects.
`timescale 1ns/10ps
module mlsd_mem_model (
  // Pointer selects
  input  logic [2:0]  x_ptr_sel_i,
  input  logic [2:0]  y_ptr_sel_i,
  input  logic [2:0]  mem_ptr_sel_i,
  // Contents seed
  input  logic [23:0] x_base_i,
  input  logic [23:0] y_base_i,
  // Read data
  output logic [23:0] x_data_o,
  output logic [23:0] y_data_o
);
  // X and memory pointers fold into the X word and the Y pointer into the Y word, so a wrong select shows up as wrong data.
  assign x_data_o = x_base_i ^ {18'h0, mem_ptr_sel_i, x_ptr_sel_i};
  assign y_data_o = y_base_i ^ {21'h0, y_ptr_sel_i};
endmodule

// *** verification/mlsd_datapath_tb_top.sv ***
// Self-checking bench of the multiply-and-load / multiply-and-subtract datapath.
`timescale 1ns/10ps
`include "mlsd_defs.svh"
module mlsd_datapath_tb_top
  import mlsd_pkg::*;
;
  logic clk, rst_n, rdy, irq, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  mlsd_instr_t instr;
  mlsd_flags_t flg;
  logic [2:0]  xps, yps, mps, st, mk;
  logic [23:0] xd, yd, xb, yb;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, d;
  logic [1:0]  bres, rres, r, vm;
  logic [51:0] ma [2];
  logic [47:0] p;
  logic [23:0] xr [2], yr [2], ar [4];
  logic        mv, z, v, n;
  int          fail_count, n_compared, k;
  mlsd_instr_t ci;
  mlsd_datapath i_mlsd_datapath (.clock_i(clk), .resetn_i(rst_n), .instr_i(instr),
    .instr_ready_o(rdy), .x_ptr_sel_o(xps), .y_ptr_sel_o(yps), .mem_ptr_sel_o(mps),
    .x_mem_data_i(xd), .y_mem_data_i(yd), .flags_o(flg), .irq_o(irq),
    .axi_awaddr_i(awa), .axi_awvalid_i(awv), .axi_awready_o(awr), .axi_wdata_i(wd),
    .axi_wstrb_i(4'hf), .axi_wvalid_i(wv), .axi_wready_o(wr), .axi_bresp_o(bres),
    .axi_bvalid_o(bv), .axi_bready_i(br), .axi_araddr_i(ara), .axi_arvalid_i(arv),
    .axi_arready_o(arr), .axi_rdata_o(rd), .axi_rresp_o(rres), .axi_rvalid_o(rv),
    .axi_rready_i(rr));
  mlsd_mem_model i_mlsd_mem_model (.x_ptr_sel_i(xps), .y_ptr_sel_i(yps),
    .mem_ptr_sel_i(mps), .x_base_i(xb), .y_base_i(yb), .x_data_o(xd), .y_data_o(yd));
  always #2 clk = ~clk;
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string s, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] w, output logic [1:0] q);
    logic dn;
    dn = 0;
    awa <= a; wd <= w; awv <= 1; wv <= 1; br <= 1;
    for (int t = 0; t < 50 && !dn; t++) begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wr) wv <= 0;
      if (bv && br) begin
        dn = 1; q = bres; br <= 0;
      end
    end
    chk("write done", dn, 1'b1);
    @(posedge clk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] o, output logic [1:0] q);
    logic dn;
    dn = 0;
    ara <= a; arv <= 1; rr <= 1;
    for (int t = 0; t < 50 && !dn; t++) begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rv && rr) begin
        dn = 1; o = rd; q = rres; rr <= 0;
      end
    end
    chk("read done", dn, 1'b1);
    @(posedge clk);
  endtask
  function automatic logic [31:0] exp_word(input logic [7:0] a);
    case (a)
      8'h0c: return {26'h0, vm, mv, z, v, n};
      8'h10: return ma[0][31:0];
      8'h14: return {12'h0, ma[0][51:32]};
      8'h18: return ma[1][31:0];
      8'h1c: return {12'h0, ma[1][51:32]};
      8'h20: return p[31:0];
      8'h24: return {16'h0, p[47:32]};
      8'h28, 8'h2c: return {8'h0, xr[a[2]]};
      8'h30, 8'h34: return {8'h0, yr[a[2]]};
      default: return {8'h0, ar[a[3:2] ^ 2'h2]};
    endcase
  endfunction
  function automatic logic top_bad(input logic [5:0] t);
    return !((&t) || !(|t));
  endfunction
  // Reference step: everything is computed from the values held before the step.
  task automatic exec(input mlsd_instr_t i, input logic [23:0] xv, input logic [23:0] yv);
    logic [51:0] ps, rs, s;
    logic [23:0] gv;
    logic        gl, ov;
    logic [1:0]  gk;
    ps = {{4{p[47]}}, p}; s = ma[i.src_acc]; gl = 0; ov = 0; gk = i.ga_dst;
    rs = (i.op == OP_SUB) ? ma[i.acc_sel] - ps : ps;
    if (i.op == OP_SUB && ma[i.acc_sel][51] != ps[51] && rs[51] != ma[i.acc_sel][51]) begin
      mv = 1; st[1] = 1;
    end
    vm[i.acc_sel] = top_bad({rs[51:47], rs[51]});
    p = $signed(xr[i.x_sel]) * $signed(yr[i.y_sel]);
    ma[i.acc_sel] = rs;
    gv = i.mem_ptr[2] ? yv : xv;
    case (i.move)
      MOVE_TWO: begin
        xr[i.x_dst] = xv; yr[i.y_dst] = yv;
      end
      MOVE_ACC: begin
        gl = 1; gv = s[47:24]; ov = top_bad({s[51:47], s[51]});
        if (i.shift == SH_RIGHT) gv = {s[47], s[47:25]};
        if (i.shift == SH_LEFT) begin
          gv = {s[46:24], 1'b0}; ov = top_bad(s[51:46]);
        end
      end
      MOVE_MEM: begin
        if (!i.mem_dst[2]) begin
          gl = 1; gk = i.mem_dst[1:0];
        end else if (i.mem_dst[1]) yr[i.mem_dst[0]] = gv;
        else xr[i.mem_dst[0]] = gv;
      end
      default: ;
    endcase
    if (gl) begin
      ar[gk] = gv; z = (gv == 0); n = gv[23]; v = ov; st[2] = st[2] | ov;
    end
    st[0] = 1;
  endtask
  task automatic iss(input mlsd_instr_t i, input logic [23:0] bx, input logic [23:0] by,
                     input logic ex);
    instr <= i; xb <= bx; yb <= by;
    @(posedge clk);
    if (ex) exec(i, bx ^ {18'h0, i.mem_ptr, 2'h0, i.x_ptr}, by ^ 24'h3);
  endtask
  function automatic mlsd_instr_t rnd_ins();
    logic [31:0] u;
    mlsd_instr_t q;
    u = $urandom;
    q = u[$bits(mlsd_instr_t)-1:0];
    q.valid = 1;
    return q;
  endfunction
  task automatic cmp_all();
    logic [31:0] e;
    for (int a = 12; a <= 68; a += 4) begin
      axr(8'(a), d, r);
      e = exp_word(8'(a));
      if (a < 40) chk($sformatf("word %h", a), d, e);
      else chk($sformatf("word %h", a), d, e);
    end
    chk("flags", flg, {vm, mv, z, v, n});
  endtask
  task automatic stat_chk();
    chk("irq", irq, |(st & mk));
    axr(`MLSD_OFF_STAT, d, r);
    chk("status", d, {29'h0, st});
    st = 0;
    chk("irq clear", irq, 1'b0);
  endtask
  initial begin
    #100000;
    fail_count++;
    $display("watchdog expired");
    wrap_up();
  end
  initial begin
    clk = 0; rst_n = 0; instr = '0; xb = 0; yb = 0; awa = 0; awv = 0; wd = 0; wv = 0;
    br = 0; ara = 0; arv = 0; rr = 0; fail_count = 0; n_compared = 0;
    ma = '{2{52'h0}}; p = 0; xr = '{2{24'h0}}; yr = '{2{24'h0}}; ar = '{4{24'h0}};
    vm = 0; mv = 0; z = 0; v = 0; n = 0; st = 0; mk = 0;
    void'($urandom(79782));
    repeat (3) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk("ready", rdy, 1'b1);
    axr(`MLSD_OFF_CTRL, d, r);
    chk("ctrl", d, 32'h1);
    axr(`MLSD_OFF_MASK, d, r);
    chk("mask", d, 32'h0);
    cmp_all();
    $display("test reset done");
    for (k = 0; k < 20; k++) begin
      mk = 3'($urandom);
      axw(`MLSD_OFF_MASK, {29'h0, mk}, r);
      repeat (1 + $urandom % 4) iss(rnd_ins(), 24'($urandom), 24'($urandom), 1);
      instr <= '0;
      @(posedge clk);
      cmp_all();
      stat_chk();
    end
    $display("test random done");
    ci = '0; ci.valid = 1; ci.move = MOVE_TWO;
    iss(ci, 24'h800000, 24'h800003, 1);
    ci.move = MOVE_NONE; ci.op = OP_SUB; ci.acc_sel = 1;
    repeat (40) iss(ci, 24'h0, 24'h0, 1);
    ci.move = MOVE_ACC; ci.src_acc = 1;
    for (k = 0; k < 3; k++) begin
      ci.shift = mlsd_shift_t'(k); ci.ga_dst = 2'(k);
      iss(ci, 24'h0, 24'h0, 1);
    end
    instr <= '0;
    @(posedge clk);
    cmp_all();
    stat_chk();
    axw(`MLSD_OFF_CTRL, 32'h3, r);
    mv = 0;
    cmp_all();
    $display("test wrap done");
    axw(`MLSD_OFF_CTRL, 32'h0, r);
    chk("ready off", rdy, 1'b0);
    iss(rnd_ins(), 24'h123456, 24'h654321, 0);
    instr <= '0;
    @(posedge clk);
    cmp_all();
    stat_chk();
    axw(`MLSD_OFF_CTRL, 32'h1, r);
    $display("test disable done");
    axr(8'h48, d, r);
    chk("rresp", r, `MLSD_RESP_DECERR);
    chk("rdata", d, 32'h0);
    axw(8'h48, 32'hffffffff, r);
    chk("bresp", r, `MLSD_RESP_DECERR);
    cmp_all();
    $display("test unmapped done");
    wrap_up();
  end
endmodule
